/* File: shared/cpbi_pkg.sv */
// cpbi_pkg: shared constants and types for the core peripheral bus
// assumes: included before the interface and both ends
package cpbi_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W_MAX = 64;
	localparam int LINE_BYTES = 32;
	localparam int BEATS_LINE_32 = 8;
	localparam int BEATS_LINE_64 = 4;
	localparam int BEATS_DOUBLE_32 = 2;
	localparam int SNOOP_DIS_BIT = 27;
	localparam int CFG_W = 32;
	localparam int CACHE_KBYTES = 16;
	localparam int CACHE_WAYS = 4;
	localparam int HIT_WORDS = 2;
	localparam int SIZE_W = 4;
	localparam int BEAT_CNT_W = 4;
	// transfer kinds on the attribute lines
	typedef enum logic [1:0] {
		CPBI_TT_ADDR_ONLY = 2'b00,
		CPBI_TT_READ = 2'b01,
		CPBI_TT_WRITE = 2'b10
	} cpbi_tt_e;
	// burst shapes
	typedef enum logic [1:0] {
		CPBI_BURST_SINGLE = 2'b00,
		CPBI_BURST_DOUBLE = 2'b01,
		CPBI_BURST_LINE = 2'b10
	} cpbi_burst_e;
	// number of beats of a burst in a given width
	function automatic logic [BEAT_CNT_W-1:0] cpbi_beats(
		input cpbi_burst_e burst, input logic wide);
		logic [BEAT_CNT_W-1:0] n;
		n = 4'h1;
		if (burst == CPBI_BURST_DOUBLE) begin
			n = BEAT_CNT_W'(BEATS_DOUBLE_32);
		end
		if (burst == CPBI_BURST_LINE) begin
			n = wide ? BEAT_CNT_W'(BEATS_LINE_64) : BEAT_CNT_W'(BEATS_LINE_32);
		end
		return n;
	endfunction
endpackage

/* File: shared/cpbi_if.sv */
// cpbi_if: signals between the core end and the central control unit
// assumes: one clock shared by both ends
`timescale 1ns/10ps
`default_nettype none
interface cpbi_if;
	// address arbitration
	logic abus_req;
	logic abus_grant;
	// address start, transfer and attributes
	logic addr_start;
	logic [cpbi_pkg::ADDR_W-1:0] addr;
	cpbi_pkg::cpbi_tt_e tt;
	cpbi_pkg::cpbi_burst_e burst;
	logic [cpbi_pkg::SIZE_W-1:0] tsize;
	logic global_snoop;
	// address termination
	logic addr_ack;
	// data arbitration and transfer
	logic dbus_grant;
	logic [cpbi_pkg::DATA_W_MAX-1:0] wdata;
	logic [cpbi_pkg::DATA_W_MAX-1:0] rdata;
	// data termination
	logic data_ack;
	// processor state
	logic core_ready;
	logic wide_mode;
	// snooping of pci memory accesses
	logic snoop_valid;
	logic [cpbi_pkg::ADDR_W-1:0] snoop_addr;
	logic snoop_hit;
	modport core (
		output abus_req, addr_start, addr, tt, burst, tsize, global_snoop,
		output wdata, core_ready, wide_mode, snoop_hit,
		input abus_grant, addr_ack, dbus_grant, rdata, data_ack,
		input snoop_valid, snoop_addr
	);
	modport ccu (
		input abus_req, addr_start, addr, tt, burst, tsize, global_snoop,
		input wdata, core_ready, wide_mode, snoop_hit,
		output abus_grant, addr_ack, dbus_grant, rdata, data_ack,
		output snoop_valid, snoop_addr
	);
endinterface
`default_nettype wire

/* File: src/cpbi_data_beats.sv */
// cpbi_data_beats: counts data beats of one data tenure
// assumes: ack pulses are one cycle each, start only when idle
`timescale 1ns/10ps
`default_nettype none
module cpbi_data_beats #(
	parameter int CNT_W = cpbi_pkg::BEAT_CNT_W
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_start,
	input wire logic [CNT_W-1:0] i_beats,
	input wire logic i_ack,
	output logic o_busy,
	output logic o_last,
	output logic [CNT_W-1:0] o_index
);
	logic [CNT_W-1:0] left;
	logic [CNT_W-1:0] next_left;
	// the counter must hold the longest burst
	if (CNT_W < cpbi_pkg::BEAT_CNT_W) begin
		$error("beat counter too narrow");
	end
	wire logic done = o_busy && i_ack && (left == CNT_W'(1));
	assign next_left = i_start ? i_beats : (i_ack ? left - CNT_W'(1) : left);
	assign o_last = o_busy && (left == CNT_W'(1));
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			left <= '0;
			o_busy <= 1'b0;
			o_index <= '0;
		end else begin
			left <= next_left;
			o_busy <= i_start | (o_busy & ~done);
			o_index <= i_start ? '0 : (o_busy && i_ack ? o_index + CNT_W'(1) : o_index);
		end
	end
endmodule
`default_nettype wire

/* File: src/cpbi_core_end.sv */
// cpbi_core_end: processor core end of the peripheral logic bus
// assumes: central control unit on the far side of cpbi_if, same clock
`timescale 1ns/10ps
`default_nettype none
module cpbi_core_end (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_data_width_select_input,
	input wire logic [cpbi_pkg::CFG_W-1:0] i_peripheral_interface_config,
	input wire logic i_req_valid,
	output logic o_req_ready,
	input wire logic [cpbi_pkg::ADDR_W-1:0] i_req_addr,
	input wire cpbi_pkg::cpbi_tt_e i_req_tt,
	input wire logic i_req_cached,
	input wire logic [cpbi_pkg::SIZE_W-1:0] i_req_size,
	input wire logic i_req_branch_pending,
	input wire logic i_req_commit,
	input wire logic [cpbi_pkg::DATA_W_MAX-1:0] i_req_wdata,
	output logic o_rd_valid,
	output logic [cpbi_pkg::DATA_W_MAX-1:0] o_rd_data,
	output logic o_done,
	output logic o_wide,
	output logic o_snoop_hit,
	input wire logic i_snoop_match,
	output logic o_size_err,
	cpbi_if.core bus
);
	typedef enum logic [1:0] {
		CPBI_A_IDLE = 2'b00,
		CPBI_A_REQ = 2'b01,
		CPBI_A_WAIT = 2'b10
	} cpbi_astate_e;
	cpbi_astate_e astate;
	cpbi_astate_e next_astate;
	logic wide;
	logic width_caught;
	logic dpend;
	logic pend_wr;
	logic [cpbi_pkg::DATA_W_MAX-1:0] d_wdata;
	logic [cpbi_pkg::ADDR_W-1:0] a_addr;
	cpbi_pkg::cpbi_tt_e a_tt;
	cpbi_pkg::cpbi_burst_e a_burst;
	logic [cpbi_pkg::SIZE_W-1:0] a_size;
	logic [cpbi_pkg::DATA_W_MAX-1:0] a_wdata;
	logic d_busy;
	logic d_last;
	// a line burst moves exactly one cache block in either width
	if (cpbi_pkg::BEATS_LINE_32 * (cpbi_pkg::ADDR_W / 8) !=
		cpbi_pkg::LINE_BYTES ||
		cpbi_pkg::BEATS_LINE_64 * (cpbi_pkg::DATA_W_MAX / 8) !=
		cpbi_pkg::LINE_BYTES) begin
		$error("line burst does not match cache block");
	end
	// a cache hit of two words fits one wide beat
	if (cpbi_pkg::HIT_WORDS * cpbi_pkg::ADDR_W != cpbi_pkg::DATA_W_MAX) begin
		$error("hit words do not fit a wide beat");
	end
	// size in bytes legal for the current width
	wire logic size_ok = (i_req_size == 4'h1) || (i_req_size == 4'h2) ||
		(i_req_size == 4'h3) || (i_req_size == 4'h4) ||
		(wide && i_req_size == 4'h8);
	// line moves are cached; non-cached go single, or double if 64-bit in 32 mode
	wire logic is_line = i_req_cached && i_req_tt != cpbi_pkg::CPBI_TT_ADDR_ONLY;
	wire logic is_double = !wide && !i_req_cached && i_req_size == 4'h8;
	wire cpbi_pkg::cpbi_burst_e req_burst = is_line ? cpbi_pkg::CPBI_BURST_LINE :
		(is_double ? cpbi_pkg::CPBI_BURST_DOUBLE : cpbi_pkg::CPBI_BURST_SINGLE);
	wire logic size_good = is_line || is_double || size_ok ||
		i_req_tt == cpbi_pkg::CPBI_TT_ADDR_ONLY;
	// stores held until branch resolved and commit given
	wire logic store_hold = i_req_tt == cpbi_pkg::CPBI_TT_WRITE &&
		(i_req_branch_pending || !i_req_commit);
	// one outstanding data tenure: a new one waits until the current one ends
	wire logic data_free = !dpend || (d_busy && d_last && bus.data_ack);
	wire logic take = astate == CPBI_A_IDLE && i_req_valid && width_caught &&
		!store_hold && size_good;
	wire logic a_done = astate == CPBI_A_WAIT && bus.addr_ack;
	wire logic a_has_data = a_tt != cpbi_pkg::CPBI_TT_ADDR_ONLY;
	wire logic snoop_on = !i_peripheral_interface_config[cpbi_pkg::SNOOP_DIS_BIT];
	assign o_req_ready = take;
	assign o_size_err = astate == CPBI_A_IDLE && i_req_valid && !size_good;
	assign o_wide = wide;
	always_comb begin
		next_astate = astate;
		unique case (astate)
			CPBI_A_IDLE: begin
				if (take) begin
					next_astate = CPBI_A_REQ;
				end
			end
			CPBI_A_REQ: begin
				// address grant while data may still run, pipelining
				if (bus.abus_grant && (!a_has_data || data_free)) begin
					next_astate = CPBI_A_WAIT;
				end
			end
			CPBI_A_WAIT: begin
				if (bus.addr_ack) begin
					next_astate = CPBI_A_IDLE;
				end
			end
		endcase
	end
	assign bus.abus_req = astate == CPBI_A_REQ;
	assign bus.addr_start = astate == CPBI_A_REQ && bus.abus_grant &&
		(!a_has_data || data_free);
	assign bus.addr = a_addr;
	assign bus.tt = a_tt;
	assign bus.burst = a_burst;
	assign bus.tsize = a_size;
	assign bus.global_snoop = a_has_data;
	assign bus.wdata = d_wdata;
	assign bus.core_ready = width_caught;
	assign bus.wide_mode = wide;
	assign bus.snoop_hit = o_snoop_hit;
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wide <= 1'b0;
			width_caught <= 1'b0;
		end else if (!width_caught) begin
			wide <= i_data_width_select_input;
			width_caught <= 1'b1;
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			astate <= CPBI_A_IDLE;
			a_addr <= '0;
			a_tt <= cpbi_pkg::CPBI_TT_ADDR_ONLY;
			a_burst <= cpbi_pkg::CPBI_BURST_SINGLE;
			a_size <= '0;
			a_wdata <= '0;
		end else begin
			astate <= next_astate;
			if (take) begin
				a_addr <= i_req_addr;
				a_tt <= i_req_tt;
				a_burst <= req_burst;
				a_size <= i_req_size;
				a_wdata <= i_req_wdata;
			end
		end
	end
	// data tenure follows an acknowledged address with data
	wire logic d_start = a_done && a_has_data;
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			dpend <= 1'b0;
			pend_wr <= 1'b0;
			d_wdata <= '0;
		end else begin
			if (d_start) begin
				dpend <= 1'b1;
				pend_wr <= a_tt == cpbi_pkg::CPBI_TT_WRITE;
				d_wdata <= a_wdata;
			end else if (d_busy && d_last && bus.data_ack) begin
				dpend <= 1'b0;
			end
		end
	end
	cpbi_data_beats u_beats (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_start(d_start),
		.i_beats(cpbi_pkg::cpbi_beats(a_burst, wide)),
		.i_ack(bus.data_ack && bus.dbus_grant),
		.o_busy(d_busy),
		.o_last(d_last),
		.o_index()
	);
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rd_valid <= 1'b0;
			o_rd_data <= '0;
			o_done <= 1'b0;
			o_snoop_hit <= 1'b0;
		end else begin
			o_rd_valid <= d_busy && bus.data_ack && bus.dbus_grant && !pend_wr;
			if (d_busy && bus.data_ack && !pend_wr) begin
				o_rd_data <= wide ? bus.rdata :
					{32'h0, bus.rdata[cpbi_pkg::DATA_W_MAX/2-1:0]};
			end
			o_done <= (a_done && !a_has_data) ||
				(d_busy && d_last && bus.data_ack && bus.dbus_grant);
			o_snoop_hit <= bus.snoop_valid && snoop_on && i_snoop_match;
		end
	end
endmodule
`default_nettype wire

/* File: src/cpbi_ccu_end.sv */
// cpbi_ccu_end: central control unit end, terminates every transaction
// assumes: user side answers reads in the same cycle as o_txn_valid
`timescale 1ns/10ps
`default_nettype none
module cpbi_ccu_end (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	output logic o_txn_valid,
	output logic [cpbi_pkg::ADDR_W-1:0] o_txn_addr,
	output logic o_txn_write,
	output logic [cpbi_pkg::BEAT_CNT_W-1:0] o_txn_beat,
	output logic [cpbi_pkg::DATA_W_MAX-1:0] o_txn_wdata,
	input wire logic [cpbi_pkg::DATA_W_MAX-1:0] i_txn_rdata,
	input wire logic i_snoop_valid,
	input wire logic [cpbi_pkg::ADDR_W-1:0] i_snoop_addr,
	output logic o_snoop_hit,
	cpbi_if.ccu bus
);
	logic d_busy;
	logic d_last;
	logic [cpbi_pkg::BEAT_CNT_W-1:0] d_index;
	logic ack;
	logic is_wr;
	logic [cpbi_pkg::ADDR_W-1:0] base;
	// address granted on request once core ready, ack next cycle; data acked every other cycle
	wire logic a_take = bus.addr_start;
	wire logic has_data = bus.tt != cpbi_pkg::CPBI_TT_ADDR_ONLY;
	wire logic [cpbi_pkg::ADDR_W-1:0] step = bus.wide_mode ?
		cpbi_pkg::ADDR_W'(8) : cpbi_pkg::ADDR_W'(4);
	assign bus.abus_grant = bus.abus_req && bus.core_ready;
	assign bus.dbus_grant = d_busy;
	assign bus.data_ack = ack;
	assign bus.snoop_valid = i_snoop_valid;
	assign bus.snoop_addr = i_snoop_addr;
	assign bus.rdata = i_txn_rdata;
	assign o_snoop_hit = bus.snoop_hit;
	cpbi_data_beats u_beats (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_start(bus.addr_ack && has_data),
		.i_beats(cpbi_pkg::cpbi_beats(bus.burst, bus.wide_mode)),
		.i_ack(ack),
		.o_busy(d_busy),
		.o_last(d_last),
		.o_index(d_index)
	);
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			bus.addr_ack <= 1'b0;
			ack <= 1'b0;
			is_wr <= 1'b0;
			base <= '0;
		end else begin
			bus.addr_ack <= a_take;
			ack <= d_busy && !ack && !(d_last && ack);
			// an address-only tenure must not disturb running data
			if (bus.addr_ack && has_data) begin
				is_wr <= bus.tt == cpbi_pkg::CPBI_TT_WRITE;
				base <= bus.addr;
			end
		end
	end
	// route each beat to the user side with its address
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_txn_valid <= 1'b0;
			o_txn_addr <= '0;
			o_txn_write <= 1'b0;
			o_txn_beat <= '0;
			o_txn_wdata <= '0;
		end else begin
			o_txn_valid <= d_busy && !ack;
			o_txn_addr <= base + step * cpbi_pkg::ADDR_W'(d_index);
			o_txn_write <= is_wr;
			o_txn_beat <= d_index;
			o_txn_wdata <= bus.wdata;
		end
	end
endmodule
`default_nettype wire

/* File: testbench/cpbi_props.sv */
// cpbi_props: wire checks between the core end and control unit end
// assumes: instantiated beside cpbi_if, one clock domain
`timescale 1ns/10ps
`default_nettype none
module cpbi_props (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic abus_req,
	input wire logic abus_grant,
	input wire logic addr_start,
	input wire cpbi_pkg::cpbi_tt_e tt,
	input wire cpbi_pkg::cpbi_burst_e burst,
	input wire logic [cpbi_pkg::SIZE_W-1:0] tsize,
	input wire logic addr_ack,
	input wire logic dbus_grant,
	input wire logic data_ack,
	input wire logic core_ready,
	input wire logic wide_mode
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	wire logic ao = tt == cpbi_pkg::CPBI_TT_ADDR_ONLY;
	wire logic st = addr_start && !ao;
	wire logic line = st && burst == cpbi_pkg::CPBI_BURST_LINE;
	wire logic one = st && burst == cpbi_pkg::CPBI_BURST_SINGLE;
	sequence beat2;
		data_ack ##1 !data_ack ##1 data_ack;
	endsequence
	sequence beat4;
		beat2 ##1 !data_ack ##1 beat2;
	endsequence
	a_start_granted: assert property (addr_start |-> abus_req && abus_grant)
		else $error("address start without grant");
	a_addr_only: assert property (addr_start && ao && !dbus_grant
		|=> addr_ack ##1 !dbus_grant ##1 !data_ack)
		else $error("address-only tenure has data");
	a_single_beat: assert property (one
		|=> addr_ack ##1 !data_ack ##1 data_ack ##1 !data_ack)
		else $error("single beat shape wrong");
	a_double_narrow: assert property (st && burst == cpbi_pkg::CPBI_BURST_DOUBLE
		|-> (!wide_mode && tsize == 4'h8) ##3 beat2) else $error("double beat wrong");
	a_line_wide: assert property (line && wide_mode |=> addr_ack ##2 beat4)
		else $error("wide line not four beats");
	a_line_narrow: assert property (line && !wide_mode |=> ##2 beat4 ##2 beat4)
		else $error("narrow line not eight beats");
	a_single_size: assert property (one |-> tsize inside {4'h1, 4'h2, 4'h3, 4'h4}
		|| (wide_mode && tsize == 4'h8)) else $error("single beat size illegal");
	a_width_fixed: assert property (core_ready && $past(core_ready)
		|-> $stable(wide_mode)) else $error("width moved after reset");
endmodule
`default_nettype wire

/* File: testbench/cpbi_bench.sv */
// cpbi_bench: joins both ends and drives their user sides
// assumes: 10 MHz clock, bench is the only stimulus source
`timescale 1ns/10ps
`default_nettype none
module cpbi_bench;
	localparam logic [63:0] RD = 64'h0123456789abcdef;
	localparam cpbi_pkg::cpbi_tt_e TR = cpbi_pkg::CPBI_TT_READ;
	localparam cpbi_pkg::cpbi_tt_e TW = cpbi_pkg::CPBI_TT_WRITE;
	localparam cpbi_pkg::cpbi_tt_e TA = cpbi_pkg::CPBI_TT_ADDR_ONLY;
	logic clk = 1'b0, rstn = 1'b0, sel = 1'b0, valid = 1'b0, cached = 1'b0;
	logic pend = 1'b0, smatch = 1'b0, svalid = 1'b0, wexp = 1'b0;
	logic commit = 1'b1;
	logic [31:0] cfg = 32'h0, addr = 32'h0, taddr;
	cpbi_pkg::cpbi_tt_e tt = TR;
	logic [3:0] size = 4'h4, tbeat;
	logic ready, rdv, done, wide, hit_c, hit_u, size_err, tvalid, twrite;
	logic [63:0] rdata, twd;
	int fails = 0, comparisons = 0, cyc = 0, nreq = 0, ndone = 0, nrd = 0;
	int nexp = 0, nhit = 0, nheld = 0;
	logic [36:0] got[$], exp[$];
	cpbi_if bus ();
	cpbi_core_end i_cpbi_core_end (.i_ref_clk(clk), .i_rstn(rstn),
		.i_data_width_select_input(sel), .i_peripheral_interface_config(cfg),
		.i_req_valid(valid), .o_req_ready(ready), .i_req_addr(addr),
		.i_req_tt(tt), .i_req_cached(cached), .i_req_size(size),
		.i_req_branch_pending(pend), .i_req_commit(commit), .i_req_wdata(RD),
		.o_rd_valid(rdv), .o_rd_data(rdata), .o_done(done), .o_wide(wide),
		.o_snoop_hit(hit_c), .i_snoop_match(smatch), .o_size_err(size_err),
		.bus(bus));
	cpbi_ccu_end i_cpbi_ccu_end (.i_ref_clk(clk), .i_rstn(rstn),
		.o_txn_valid(tvalid), .o_txn_addr(taddr), .o_txn_write(twrite),
		.o_txn_beat(tbeat), .o_txn_wdata(twd), .i_txn_rdata(RD),
		.i_snoop_valid(svalid), .i_snoop_addr(32'h0000_1000),
		.o_snoop_hit(hit_u), .bus(bus));
	cpbi_props i_cpbi_props (.i_ref_clk(clk), .i_rstn(rstn),
		.abus_req(bus.abus_req), .abus_grant(bus.abus_grant),
		.addr_start(bus.addr_start), .tt(bus.tt), .burst(bus.burst),
		.tsize(bus.tsize), .addr_ack(bus.addr_ack),
		.dbus_grant(bus.dbus_grant), .data_ack(bus.data_ack),
		.core_ready(bus.core_ready), .wide_mode(bus.wide_mode));
	always #50 clk = ~clk;
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			stop_test();
		end
		if (tvalid) got.push_back({tbeat == 4'h0 ? taddr : 32'h0, twrite, tbeat});
		if (tvalid && twrite) chk("txn wdata", RD, twd);
		if (rdv) nrd++;
		if (rdv) chk("rd data", wexp ? RD : {32'h0, RD[31:0]}, rdata);
		if (done) ndone++;
		nhit = nhit + int'(hit_c) + int'(hit_u);
	end
	task automatic issue(input logic [31:0] a, input cpbi_pkg::cpbi_tt_e t,
		input logic c, input logic [3:0] s);
		int n;
		n = t == TA ? 0 : c ? (wexp ? 4 : 8) : (!wexp && s == 4'h8) ? 2 : 1;
		addr = a;
		tt = t;
		cached = c;
		size = s;
		pend = 1'b0;
		commit = 1'b1;
		valid = 1'b1;
		for (int i = 0; i < n; i++) exp.push_back({i == 0 ? a : 32'h0, t == TW, 4'(i)});
		if (t == TR) nexp = nexp + n;
		nreq++;
		repeat (40) begin
			@(negedge clk);
			if (ready) break;
		end
		chk("req taken", 1, ready);
		@(posedge clk);
		#1;
	endtask
	task automatic drain();
		valid = 1'b0;
		repeat (400) if (ndone < nreq) @(posedge clk);
		#1;
		chk("done count", nreq, ndone);
		chk("beat count", exp.size(), got.size());
		foreach (exp[i]) chk("txn beat", exp[i], got[i]);
		chk("read beats", nexp, nrd);
		exp.delete();
		got.delete();
		{nreq, ndone, nexp, nrd} = '0;
	endtask
	initial begin
		for (int w = 0; w < 2; w++) begin
			rstn = 1'b0;
			sel = w[0];
			wexp = w[0];
			repeat (5) @(posedge clk);
			#1;
			rstn = 1'b1;
			repeat (2) @(posedge clk);
			#1;
			chk("width", wexp, wide);
			sel = ~sel;
			issue(32'h0fc, TA, 1'b0, 4'h4);
			for (int s = 1; s <= 4; s++) issue(32'h100 + s, TR, 1'b0, 4'(s));
			issue(32'h200, TR, 1'b0, 4'h8);
			issue(32'h300, TW, 1'b0, 4'h8);
			issue(32'h400, TA, 1'b0, 4'h4);
			issue(32'h500, TR, 1'b1, 4'h4);
			issue(32'h600, TW, 1'b1, 4'h4);
			drain();
			chk("width held", wexp, wide);
			addr = 32'h700;
			tt = TW;
			{cached, pend, valid} = 3'b011;
			nheld = 0;
			repeat (8) @(negedge clk) if (ready) nheld++;
			@(posedge clk);
			#1;
			{pend, commit} = 2'b00;
			repeat (4) @(negedge clk) if (ready) nheld++;
			chk("held store", 0, nheld);
			@(posedge clk);
			#1;
			size = 4'h5;
			commit = 1'b1;
			@(negedge clk);
			chk("size refused", 2'b10, {size_err, ready});
			@(posedge clk);
			#1;
			issue(32'h700, TW, 1'b0, 4'h4);
			drain();
			for (int en = 0; en < 2; en++) begin
				cfg = en ? 32'h0 : 32'h0800_0000;
				smatch = 1'b1;
				svalid = 1'b1;
				nhit = 0;
				@(posedge clk);
				#1;
				svalid = 1'b0;
				repeat (5) @(posedge clk);
				#1;
				chk("snoop hit", en, nhit != 0);
			end
		end
		stop_test();
	end
endmodule
`default_nettype wire
